// [inc/mrf_regs.svh]
// register offsets, control bit positions and timing counts of the receive filter block
`ifndef MRF_REGS_SVH
`define MRF_REGS_SVH

`define MRF_CTRL_ADDR       16'h0000
`define MRF_DROP_STAT_ADDR  16'h0052
`define MRF_CTRL_RESET      32'h0000_0000
`define MRF_CTRL_WMASK      32'h003f_0000

`define MRF_BIT_GAP_OFF     21
`define MRF_BIT_BACKOFF_DIS 20
`define MRF_BIT_FCS_PASS    19
`define MRF_BIT_GRP_DISCARD 18
`define MRF_BIT_ONES_DISC   17
`define MRF_BIT_MATCH_EN    16

`define MRF_CLK_NS          20
`define MRF_IPG_NS          9600
`define MRF_IPG_CYC         (`MRF_IPG_NS / `MRF_CLK_NS)
`define MRF_IPG_GLITCH_CYC  ((`MRF_IPG_CYC * 2) / 3)
`define MRF_SLOT_NS         51200
`define MRF_SLOT_CYC        (`MRF_SLOT_NS / `MRF_CLK_NS)
`define MRF_DA_BYTES        6

`endif

// [inc/mrf_pkg.sv]
// types shared by the receive filter block
package mrf_pkg;
    typedef logic [47:0] mrf_mac_addr_t;
    typedef logic [10:0] mrf_word_t;
    typedef enum logic {MRF_BO_IDLE, MRF_BO_WAIT} mrf_bo_state_t;
endpackage

// [core/mrf_skid_fifo.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module mrf_skid_fifo
    import mrf_pkg::*;
(
    // clock and reset
    input  wire logic      clk_sys_in,
    input  wire logic      rst_n_in,
    // fill side
    input  wire logic      in_valid_in,
    input  wire mrf_word_t in_word_in,
    output logic           in_ready_out,
    // drain side
    output logic           out_valid_out,
    output mrf_word_t      out_word_out,
    input  wire logic      out_ready_in
);
    mrf_word_t  mem_q [2];
    logic       wr_ptr_q;
    logic       rd_ptr_q;
    logic [1:0] count_q;
    logic       push;
    logic       pop;

    assign in_ready_out  = (count_q != 2'h2);
    assign out_valid_out = (count_q != 2'h0);
    assign out_word_out  = mem_q[rd_ptr_q];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem_q[0] <= 11'h000;
            mem_q[1] <= 11'h000;
        end
        else if (push)
        begin
            mem_q[wr_ptr_q] <= in_word_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= ~wr_ptr_q;
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // mrf_skid_fifo

// [core/mrf_rx_filter.sv]
// mac control word upper half: gap glitch filter, back-off, receive frame filters
`timescale 1ns/1ns
`include "mrf_regs.svh"
module mrf_rx_filter
    import mrf_pkg::*;
(
    // clock and reset
    input  wire logic          clk_sys_in,
    input  wire logic          rst_n_in,
    // register access
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    input  wire logic [15:0]   reg_addr_in,
    input  wire logic [31:0]   reg_wdata_in,
    output logic      [31:0]   reg_rdata_out,
    // destination match entry
    input  wire mrf_mac_addr_t dest_match_value_in,
    input  wire mrf_mac_addr_t dest_match_mask_in,
    input  wire logic          dest_match_entry_en_in,
    // receive stream from the phy side
    input  wire logic          rx_valid_in,
    input  wire logic [7:0]    rx_data_in,
    input  wire logic          rx_last_in,
    input  wire logic          rx_fcs_bad_in,
    output logic               rx_ready_out,
    // stream towards the host
    output logic               host_valid_out,
    output logic      [7:0]    host_data_out,
    output logic               host_last_out,
    output logic               host_keep_out,
    output logic               footer_drop_flag_out,
    input  wire logic          host_ready_in,
    // statistics and transmit timing
    output logic               rx_dropped_inc_out,
    input  wire logic          crs_in,
    output logic               ipg_done_out,
    input  wire logic          collision_in,
    input  wire logic [9:0]    backoff_slots_in,
    output logic               retransmit_out
);
    localparam logic [9:0]  IPG_CYC   = 10'(`MRF_IPG_CYC);
    localparam logic [9:0]  IPG_GLT   = 10'(`MRF_IPG_GLITCH_CYC);
    localparam logic [11:0] SLOT_CYC  = 12'(`MRF_SLOT_CYC);
    localparam logic [2:0]  DA_LAST   = 3'(`MRF_DA_BYTES - 1);

    function automatic logic is_all_ones(input mrf_mac_addr_t a);
        return &a;
    endfunction

    function automatic logic is_group(input mrf_mac_addr_t a);
        return a[0];
    endfunction

    // control word
    logic [31:0] ctrl_q;
    logic        gap_off;
    logic        backoff_dis;
    logic        fcs_pass;
    logic        grp_disc;
    logic        ones_disc;
    logic        match_en;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ctrl_q <= `MRF_CTRL_RESET;
        else if (reg_wr_in && reg_addr_in == `MRF_CTRL_ADDR)
            ctrl_q <= reg_wdata_in & `MRF_CTRL_WMASK;
    end

    assign gap_off     = ctrl_q[`MRF_BIT_GAP_OFF];
    assign backoff_dis = ctrl_q[`MRF_BIT_BACKOFF_DIS];
    assign fcs_pass    = ctrl_q[`MRF_BIT_FCS_PASS];
    assign grp_disc    = ctrl_q[`MRF_BIT_GRP_DISCARD];
    assign ones_disc   = ctrl_q[`MRF_BIT_ONES_DISC];
    assign match_en    = ctrl_q[`MRF_BIT_MATCH_EN];

    // unmapped reads answer zero; lower control bits live elsewhere
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_rd_in)
            reg_rdata_out <= (reg_addr_in == `MRF_CTRL_ADDR) ? ctrl_q : 32'h0000_0000;
    end

    // carrier sense comes from the pin: three stages, accept when last two agree
    logic crs_s1_q;
    logic crs_s2_q;
    logic crs_s3_q;
    logic crs_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            crs_s1_q <= 1'b0;
            crs_s2_q <= 1'b0;
            crs_s3_q <= 1'b0;
            crs_q    <= 1'b0;
        end
        else
        begin
            crs_s1_q <= crs_in;
            crs_s2_q <= crs_s1_q;
            crs_s3_q <= crs_s2_q;
            if (crs_s2_q == crs_s3_q)
                crs_q <= crs_s3_q;
        end
    end

    // inter-packet gap counter
    logic [9:0] ipg_cnt_q;
    logic       gap_open_q;
    logic       glitch_ignored;

    assign glitch_ignored = !gap_off && gap_open_q && crs_q && (ipg_cnt_q < IPG_GLT);

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ipg_cnt_q  <= 10'h000;
            gap_open_q <= 1'b0;
        end
        else if (crs_q && !glitch_ignored)
        begin
            ipg_cnt_q  <= 10'h000;
            gap_open_q <= 1'b0;
        end
        else
        begin
            gap_open_q <= 1'b1;
            if (ipg_cnt_q < IPG_CYC)
                ipg_cnt_q <= ipg_cnt_q + 10'h001;
        end
    end

    assign ipg_done_out = gap_open_q && (ipg_cnt_q == IPG_CYC) && !crs_q;

    // back-off after a collision, counted in slot times
    mrf_bo_state_t bo_state_q;
    logic [11:0]   slot_cyc_q;
    logic [9:0]    slots_left_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bo_state_q     <= MRF_BO_IDLE;
            slot_cyc_q     <= 12'h000;
            slots_left_q   <= 10'h000;
            retransmit_out <= 1'b0;
        end
        else
        begin
            retransmit_out <= 1'b0;
            case (bo_state_q)
                MRF_BO_IDLE:
                begin
                    if (collision_in)
                    begin
                        if (backoff_dis || backoff_slots_in == 10'h000)
                            retransmit_out <= 1'b1;
                        else
                        begin
                            bo_state_q   <= MRF_BO_WAIT;
                            slot_cyc_q   <= 12'h000;
                            slots_left_q <= backoff_slots_in;
                        end
                    end
                end
                MRF_BO_WAIT:
                begin
                    if (slot_cyc_q == SLOT_CYC - 12'h001)
                    begin
                        slot_cyc_q   <= 12'h000;
                        slots_left_q <= slots_left_q - 10'h001;
                        if (slots_left_q == 10'h001)
                        begin
                            retransmit_out <= 1'b1;
                            bo_state_q     <= MRF_BO_IDLE;
                        end
                    end
                    else
                        slot_cyc_q <= slot_cyc_q + 12'h001;
                end
                default:
                    bo_state_q <= MRF_BO_IDLE;
            endcase
        end
    end

    // destination capture; byte 0 lands in the low bits so its lsb is the group bit
    mrf_mac_addr_t da_q;
    mrf_mac_addr_t da_full;
    logic [2:0]    byte_idx_q;
    logic          addr_drop_q;
    logic          in_take;
    logic          da_done;
    logic          grp_hit;
    logic          ones_hit;
    logic          match_hit;
    logic          match_drop;
    logic          addr_drop_now;
    logic          drop_eff;
    logic          fcs_drop;
    logic          push;
    logic          fifo_ready;
    mrf_word_t     push_word;
    mrf_word_t     pop_word;

    assign in_take  = rx_valid_in && fifo_ready;
    assign da_done  = in_take && (byte_idx_q == DA_LAST);
    assign da_full  = {rx_data_in, da_q[39:0]};
    assign ones_hit = ones_disc && is_all_ones(da_full);
    assign grp_hit  = grp_disc && is_group(da_full) && !is_all_ones(da_full);
    assign match_hit  = dest_match_entry_en_in && match_en
                        && (((da_full ^ dest_match_value_in) & dest_match_mask_in) == 48'h0);
    assign match_drop = match_en && !match_hit;
    assign addr_drop_now = da_done && (grp_hit || ones_hit || match_drop);
    assign drop_eff = addr_drop_q || addr_drop_now;
    assign fcs_drop = rx_fcs_bad_in && !fcs_pass;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            da_q        <= 48'h0;
            byte_idx_q  <= 3'h0;
            addr_drop_q <= 1'b0;
        end
        else if (in_take)
        begin
            if (byte_idx_q <= DA_LAST)
                da_q[byte_idx_q * 8 +: 8] <= rx_data_in;
            if (rx_last_in)
            begin
                byte_idx_q  <= 3'h0;
                addr_drop_q <= 1'b0;
            end
            else
            begin
                if (byte_idx_q <= DA_LAST)
                    byte_idx_q <= byte_idx_q + 3'h1;
                if (addr_drop_now)
                    addr_drop_q <= 1'b1;
            end
        end
    end

    // statistics pulse, one per frame the group or all-ones filter discards
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rx_dropped_inc_out <= 1'b0;
        else
            rx_dropped_inc_out <= da_done && (grp_hit || ones_hit);
    end

    // a dropped frame still pushes its last word so the host side can roll back
    assign push      = in_take && (rx_last_in || !drop_eff);
    assign push_word = {rx_data_in, rx_last_in, rx_last_in && !(drop_eff || fcs_drop),
                        rx_last_in && rx_fcs_bad_in};

    mrf_skid_fifo u_fifo
    (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (push),
        .in_word_in    (push_word),
        .in_ready_out  (fifo_ready),
        .out_valid_out (host_valid_out),
        .out_word_out  (pop_word),
        .out_ready_in  (host_ready_in)
    );

    // the source stalls on a full buffer, so no byte is lost
    assign rx_ready_out         = fifo_ready;
    assign host_data_out        = pop_word[10:3];
    assign host_last_out        = pop_word[2];
    assign host_keep_out        = pop_word[1];
    assign footer_drop_flag_out = pop_word[0];

    ctrl_reserved_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        reg_rd_in |=> reg_rdata_out[31:22] == 10'h000 && reg_rdata_out[15:0] == 16'h0000)
        else $error("unused control bits read nonzero");

    gap_off_ctrl_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        reg_wr_in && reg_addr_in == `MRF_CTRL_ADDR |=> gap_off == $past(reg_wdata_in[`MRF_BIT_GAP_OFF]))
        else $error("gap filter disable bit not stored");

    gap_glitch_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !gap_off && gap_open_q && crs_q && ipg_cnt_q < IPG_GLT && ipg_cnt_q != 10'h000
        |=> ipg_cnt_q == $past(ipg_cnt_q) + 10'h001)
        else $error("gap counter restarted by early glitch");

    backoff_skip_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        bo_state_q == MRF_BO_IDLE && collision_in && backoff_dis |=> retransmit_out ##1 !retransmit_out)
        else $error("no immediate retransmit with back-off off");

    fcs_drop_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        push && rx_last_in && rx_fcs_bad_in && !fcs_pass |-> !push_word[1])
        else $error("bad checksum frame kept");

    footer_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        push && rx_last_in && rx_fcs_bad_in && push_word[1] |-> push_word[0] && fcs_pass)
        else $error("forwarded bad frame lacks footer flag");

    group_count_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        da_done && grp_disc && !is_all_ones(da_full) && da_q[0]
        |=> rx_dropped_inc_out ##1 !rx_dropped_inc_out)
        else $error("group discard not counted once");

    ones_spared_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        da_done && is_all_ones(da_full) && !ones_disc && !match_en |=> !addr_drop_q)
        else $error("all-ones frame dropped by group filter");

    promisc_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        da_done && !match_en && !grp_disc && !ones_disc && !rx_last_in |=> !addr_drop_q)
        else $error("frame dropped in promiscuous mode");
endmodule // mrf_rx_filter

// [verif/mrf_host_sink.sv]
// host side model: drains the filtered stream with periodic stalls
`timescale 1ns/1ns
module mrf_host_sink
    import mrf_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // stream from the device
    input  wire logic        host_valid_in,
    input  wire logic        host_last_in,
    input  wire logic        host_keep_in,
    input  wire logic        footer_drop_flag_in,
    output logic             host_ready_out,
    // observed frame ends
    output logic             last_keep_out,
    output logic             last_flag_out,
    output logic [15:0]      frames_out
);
    int phase = 0;

    // stall one cycle in three so the two-entry buffer fills and refuses
    always @(negedge clk_sys_in)
    begin
        phase <= phase + 1;
        host_ready_out <= (phase % 3) != 2;
    end

    always @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            frames_out <= 16'h0000;
            last_keep_out <= 1'b0;
            last_flag_out <= 1'b0;
        end
        else if (host_valid_in && host_ready_out && host_last_in)
        begin
            last_keep_out <= host_keep_in;
            last_flag_out <= footer_drop_flag_in;
            frames_out <= frames_out + 16'h0001;
        end
    end
endmodule // mrf_host_sink

// [verif/tb_top.sv]
// self-checking testbench of the receive filter block
`timescale 1ns/1ns
`include "mrf_regs.svh"
module tb_top
    import mrf_pkg::*;
;
    logic          clk, rst_n, wr, rd, ent_en, rx_valid, rx_last, fcs_bad, rx_ready;
    logic          h_valid, h_last, h_keep, h_flag, h_ready, inc, crs, ipg_done, coll, retx, last_keep, last_flag;
    logic [15:0]   addr, frames;
    logic [31:0]   wdata, rdata;
    logic [7:0]    rx_data, h_data, last_data;
    logic [9:0]    slots;
    mrf_mac_addr_t m_val, m_mask;
    int            failures = 0, checked = 0, drops = 0;
    localparam mrf_mac_addr_t GRP  = 48'h02_4c_aa_09_54_01;
    localparam mrf_mac_addr_t UNI  = 48'h07_98_65_fc_2d_84;
    localparam mrf_mac_addr_t ONES = 48'hff_ff_ff_ff_ff_ff;

    mrf_rx_filter u_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .dest_match_value_in(m_val), .dest_match_mask_in(m_mask),
        .dest_match_entry_en_in(ent_en), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_last_in(rx_last),
        .rx_fcs_bad_in(fcs_bad), .rx_ready_out(rx_ready), .host_valid_out(h_valid), .host_data_out(h_data),
        .host_last_out(h_last), .host_keep_out(h_keep), .footer_drop_flag_out(h_flag), .host_ready_in(h_ready),
        .rx_dropped_inc_out(inc), .crs_in(crs), .ipg_done_out(ipg_done), .collision_in(coll),
        .backoff_slots_in(slots), .retransmit_out(retx));

    mrf_host_sink u_sink (.clk_sys_in(clk), .rst_n_in(rst_n), .host_valid_in(h_valid), .host_last_in(h_last),
        .host_keep_in(h_keep), .footer_drop_flag_in(h_flag), .host_ready_out(h_ready),
        .last_keep_out(last_keep), .last_flag_out(last_flag), .frames_out(frames));

    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (inc === 1'b1)
            drops <= drops + 1;
        if (h_valid && h_ready && h_last)
            last_data <= h_data;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        wr = 1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 0;
    endtask

    task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
        @(negedge clk);
        rd = 1;
        addr = a;
        @(negedge clk);
        rd = 0;
        d = rdata;
    endtask

    // ten-byte frame; the footer flag must follow the checksum state either way
    task automatic frame(input mrf_mac_addr_t da, input logic bad, input logic keep, input logic drop);
        logic [15:0] f0;
        int          d0, i;
        f0 = frames;
        d0 = drops;
        for (i = 0; i < 10; i++)
        begin
            @(negedge clk);
            rx_valid = 1;
            rx_data = (i < 6) ? da[8*i +: 8] : 8'(i);
            rx_last = (i == 9);
            fcs_bad = bad;
            while (rx_ready !== 1'b1)
                @(negedge clk);
            @(posedge clk);
        end
        @(negedge clk);
        rx_valid = 0;
        rx_last = 0;
        i = 0;
        while (frames == f0 && i < 50)
        begin
            @(negedge clk);
            i++;
        end
        chk("frame end", 1, 32'(frames != f0));
        chk("last byte", 32'h0000_0009, 32'(last_data));
        chk("keep", 32'(keep), 32'(last_keep));
        chk("footer flag", 32'(bad), 32'(last_flag));
        chk("drop count", 32'(drop), 32'(drops - d0));
    endtask

    task automatic test_regs;
        logic [31:0] d;
        chk("ready idle", 1, 32'(rx_ready));
        reg_read(`MRF_CTRL_ADDR, d);
        chk("control reset", 32'h0000_0000, d);
        reg_write(`MRF_CTRL_ADDR, 32'hffff_ffff);
        reg_read(`MRF_CTRL_ADDR, d);
        chk("control writable", 32'h003f_0000, d);
        reg_write(16'h0005, 32'h0000_0000);
        reg_read(16'h0005, d);
        chk("unmapped read", 32'h0000_0000, d);
        reg_read(`MRF_CTRL_ADDR, d);
        chk("control kept", 32'h003f_0000, d);
        reg_write(`MRF_CTRL_ADDR, 32'h0000_0000);
        $display("register test done");
    endtask

    task automatic test_group;
        reg_write(`MRF_CTRL_ADDR, 32'h1 << `MRF_BIT_GRP_DISCARD);
        frame(GRP, 0, 0, 1);
        frame(UNI, 0, 1, 0);
        frame(ONES, 0, 1, 0);
        reg_write(`MRF_CTRL_ADDR, 32'h3 << `MRF_BIT_ONES_DISC);
        frame(ONES, 0, 0, 1);
        reg_write(`MRF_CTRL_ADDR, 32'h1 << `MRF_BIT_ONES_DISC);
        frame(GRP, 0, 1, 0);
        $display("group and all-ones test done");
    endtask

    task automatic test_match;
        m_val = UNI;
        m_mask = ONES;
        ent_en = 1;
        reg_write(`MRF_CTRL_ADDR, 32'h1 << `MRF_BIT_MATCH_EN);
        frame(UNI, 0, 1, 0);
        frame(UNI ^ 48'h00_00_00_10_00_00, 0, 0, 0);
        ent_en = 0;
        frame(UNI, 0, 0, 0);
        reg_write(`MRF_CTRL_ADDR, 32'h0000_0000);
        frame(GRP, 0, 1, 0);
        ent_en = 1;
        $display("match test done");
    endtask

    task automatic test_fcs;
        frame(UNI, 1, 0, 0);
        reg_write(`MRF_CTRL_ADDR, 32'h1 << `MRF_BIT_FCS_PASS);
        frame(UNI, 1, 1, 0);
        reg_write(`MRF_CTRL_ADDR, 32'h0000_0000);
        $display("checksum test done");
    endtask

    // glitch early in the gap; filter on keeps the count, filter off restarts it
    task automatic test_gap(input logic off, input logic exp);
        reg_write(`MRF_CTRL_ADDR, 32'(off) << `MRF_BIT_GAP_OFF);
        crs = 1;
        repeat (10) @(negedge clk);
        crs = 0;
        repeat (100) @(negedge clk);
        crs = 1;
        repeat (2) @(negedge clk);
        crs = 0;
        repeat (398) @(negedge clk);
        chk("gap done", 32'(exp), 32'(ipg_done));
        repeat (200) @(negedge clk);
        chk("gap done late", 1, 32'(ipg_done));
        reg_write(`MRF_CTRL_ADDR, 32'h0000_0000);
        $display("gap test done");
    endtask

    task automatic pulse_coll(input logic [9:0] s);
        @(negedge clk);
        coll = 1;
        slots = s;
        @(negedge clk);
        coll = 0;
    endtask

    task automatic test_backoff;
        int n;
        reg_write(`MRF_CTRL_ADDR, 32'h1 << `MRF_BIT_BACKOFF_DIS);
        pulse_coll(10'h005);
        chk("retransmit at once", 1, 32'(retx));
        reg_write(`MRF_CTRL_ADDR, 32'h0000_0000);
        pulse_coll(10'h001);
        n = 0;
        while (retx !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        chk("backoff wait", 1, 32'(n > 2550 && n < 2570));
        $display("backoff test done");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("Error watchdog expected finish seen timeout");
        report_and_stop;
    end

    initial
    begin
        {rst_n, wr, rd, rx_valid, rx_last, fcs_bad, crs, coll} = '0;
        {addr, wdata, rx_data, slots} = '0;
        m_val = '0;
        m_mask = '0;
        ent_en = 1;
        repeat (10) @(negedge clk);
        rst_n = 1;
        test_regs;
        test_group;
        test_match;
        test_fcs;
        test_gap(0, 1);
        test_gap(1, 0);
        test_backoff;
        report_and_stop;
    end
endmodule // tb_top
